//--- src/timer8_pkg.sv
package timer8_pkg;

  // ****************************************************************
  // Register map, Wishbone word addresses as byte offsets.
  // ****************************************************************
  localparam logic [3:0] ADDR_COUNTER = 4'h0;
  localparam logic [3:0] ADDR_OPTION = 4'h4;
  localparam logic [3:0] ADDR_INTCTL = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;
  localparam logic [4:0] ADDR_IRQ_MASK_HI = 5'h10;
  localparam logic [4:0] ADDR_DOG_CLEAR = 5'h14;
  localparam logic [4:0] ADDR_COUNTER_W = 5'h00;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int OPT_CLK_SRC = 5;
  localparam int OPT_EDGE = 4;
  localparam int OPT_ASSIGN = 3;
  localparam int INT_GLOBAL_EN = 7;
  localparam int INT_OVF_IE = 5;
  localparam int INT_OVF_FLAG = 2;

  // ****************************************************************
  // Reset values and timing.
  // ****************************************************************
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] INTCTL_WMASK = 8'hFB;
  localparam int CLKS_PER_INSN = 4;
  localparam logic [1:0] INSN_DIV_MAX = 2'(CLKS_PER_INSN - 1);
  localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;

endpackage

//--- src/prescaler8.sv
`timescale 1ns/1ps
`default_nettype none

// Shared 8-bit ripple-style prescaler; the count itself is never
// visible to software, only a pulse when the selected tap falls.
module prescaler8 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [2:0] rate_i,
  output logic pulse_o
);
  import timer8_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic pulse;
  } pre_state_s;

  pre_state_s state_reg;
  pre_state_s state_next;
  logic [7:0] incr;

  always_comb begin
    state_next = state_reg;
    incr = state_reg.count + 8'h01;
    state_next.pulse = 1'b0;
    if (clear_i) begin
      state_next.count = 8'h00;
    end else if (tick_i) begin
      state_next.count = incr;
      // A carry out of bit n marks one period of 2^(n+1) ticks.
      state_next.pulse = incr[rate_i] & ~state_reg.count[rate_i] ?
        1'b0 : (~incr[rate_i] & state_reg.count[rate_i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pulse_o = state_reg.pulse;

endmodule

`default_nettype wire

//--- src/timer8.sv
// Functional notes
// - Timer mode counts every instruction cycle when the prescaler is on watchdog.
// - Counter write suppresses increments for two instruction cycles.
// - Counter mode counts selected external input edges.
// - One prescaler, timer when assign bit clear.
// - Rate field picks 1:2 through 1:256.
// - 1:1 only with prescaler on watchdog.
// - Counter write clears prescaler when timer-assigned.
// - Watchdog clear clears prescaler when watchdog-assigned.
// - Wrap FFh to 00h sets overflow flag.
// - Overflow flag stays until software clears.
// - Interrupt needs overflow flag and enable.
// - Sleep freezes the counter.
// - Eight-bit counter and eight-bit prescaler.
// - Assign bit set gives prescaler to watchdog.
// - Global enable gates the timer and other requests, not irq_status.
`timescale 1ns/1ps
`default_nettype none

module timer8 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sleep_i,
  input wire logic external_count_input_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic [7:0] other_irq_i,
  output logic watchdog_tick_o,
  output logic watchdog_clear_o,
  output logic timer_irq_o,
  output logic irq_o
);
  import timer8_pkg::*;

  // ****************************************************************
  // Module state.
  // ****************************************************************
  typedef struct packed {
    bus_state_e bus;
    logic [31:0] rdata;
    logic [7:0] counter_register;
    logic [7:0] option_control;
    logic [7:0] interrupt_control;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] insn_div;
    logic [1:0] hold;
    logic ext_prev;
  } tmr_state_s;

  tmr_state_s state_reg;
  tmr_state_s state_next;

  logic insn_tick;
  logic ext_edge;
  logic src_tick;
  logic pre_tick;
  logic pre_clear;
  logic pre_pulse;
  logic count_en;
  logic access;
  logic wr;
  logic counter_wr;
  logic dog_clr_wr;
  logic prescaler_to_dog;
  logic overflow;
  logic [7:0] wsel;
  logic [31:0] rd_mux;

  // ****************************************************************
  // Count path.
  // ****************************************************************
  assign access = cyc_i & stb_i & (state_reg.bus == BUS_IDLE);
  assign wr = access & we_i & sel_i[0];
  assign wsel = dat_i[7:0];
  assign counter_wr = wr & (adr_i == ADDR_COUNTER_W);
  assign dog_clr_wr = wr & (adr_i == ADDR_DOG_CLEAR) & dat_i[0];
  assign prescaler_to_dog = state_reg.option_control[OPT_ASSIGN];
  // The instruction cycle lasts four clocks; Sleep stops it.
  assign insn_tick = (state_reg.insn_div == INSN_DIV_MAX) & ~sleep_i;
  // External input is taken as synchronous; edge detected on every
  // clock against the sample taken on the previous clock.
  assign ext_edge = state_reg.option_control[OPT_EDGE] ?
    (state_reg.ext_prev & ~external_count_input_i) :
    (~state_reg.ext_prev & external_count_input_i);
  assign src_tick = state_reg.option_control[OPT_CLK_SRC] ?
    (ext_edge & ~sleep_i) : insn_tick;
  assign pre_tick = ~prescaler_to_dog ? src_tick : insn_tick;
  assign pre_clear = (counter_wr & ~prescaler_to_dog) |
    ((watchdog_clear_instruction_i | dog_clr_wr) & prescaler_to_dog);
  assign count_en = (prescaler_to_dog ? src_tick : pre_pulse) &
    (state_reg.hold == 2'h0);
  assign overflow = count_en & ~counter_wr &
    (state_reg.counter_register == 8'hFF);

  prescaler8 u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(pre_clear),
    .tick_i(pre_tick),
    .rate_i(state_reg.option_control[2:0]),
    .pulse_o(pre_pulse)
  );

  // ****************************************************************
  // Register read mux.
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr_i == ADDR_COUNTER_W) begin
      rd_mux[7:0] = state_reg.counter_register;
    end else if (adr_i[3:0] == ADDR_OPTION && !adr_i[4]) begin
      rd_mux[7:0] = state_reg.option_control;
    end else if (adr_i[3:0] == ADDR_INTCTL && !adr_i[4]) begin
      rd_mux[7:0] = state_reg.interrupt_control;
    end else if (adr_i[3:0] == ADDR_IRQ_STATUS && !adr_i[4]) begin
      rd_mux[1:0] = state_reg.irq_status;
    end else if (adr_i == ADDR_IRQ_MASK_HI) begin
      rd_mux[1:0] = state_reg.irq_mask;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.ext_prev = external_count_input_i;
    if (!sleep_i) begin
      state_next.insn_div = state_reg.insn_div + 2'h1;
    end
    if (insn_tick && state_reg.hold != 2'h0) begin
      state_next.hold = state_reg.hold - 2'h1;
    end
    if (count_en) begin
      state_next.counter_register = state_reg.counter_register + 8'h01;
    end
    // Bus handshake; unmapped reads return zero, writes are dropped.
    if (state_reg.bus == BUS_ACK) begin
      state_next.bus = BUS_IDLE;
    end else if (access) begin
      state_next.bus = BUS_ACK;
      state_next.rdata = rd_mux;
    end
    if (wr) begin
      if (adr_i == ADDR_COUNTER_W) begin
        state_next.counter_register = wsel;
        state_next.hold = WRITE_HOLD_CYCLES;
      end else if (adr_i[3:0] == ADDR_OPTION && !adr_i[4]) begin
        state_next.option_control = wsel;
      end else if (adr_i[3:0] == ADDR_INTCTL && !adr_i[4]) begin
        // Writing the flag bit only ever lets software clear it.
        state_next.interrupt_control = (wsel & INTCTL_WMASK) |
          (wsel & state_reg.interrupt_control &
          ~INTCTL_WMASK);
      end else if (adr_i[3:0] == ADDR_IRQ_STATUS && !adr_i[4]) begin
        state_next.irq_status = state_reg.irq_status & ~dat_i[1:0];
      end else if (adr_i == ADDR_IRQ_MASK_HI) begin
        state_next.irq_mask = dat_i[1:0];
      end
    end
    // Hardware set wins over a simultaneous software clear.
    if (overflow) begin
      state_next.interrupt_control[INT_OVF_FLAG] = 1'b1;
      state_next.irq_status[0] = 1'b1;
    end
    if (pre_clear && prescaler_to_dog) begin
      state_next.irq_status[1] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.bus <= BUS_IDLE;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.counter_register <= 8'h00;
      state_reg.option_control <= OPTION_RESET;
      state_reg.interrupt_control <= INTCTL_RESET;
      state_reg.irq_status <= 2'h0;
      state_reg.irq_mask <= 2'h0;
      state_reg.insn_div <= 2'h0;
      state_reg.hold <= 2'h0;
      state_reg.ext_prev <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign ack_o = (state_reg.bus == BUS_ACK);
  assign dat_o = state_reg.rdata;
  assign watchdog_tick_o = prescaler_to_dog ? pre_pulse : insn_tick;
  assign watchdog_clear_o = watchdog_clear_instruction_i | dog_clr_wr;
  assign timer_irq_o = state_reg.interrupt_control[INT_GLOBAL_EN] &
    state_reg.interrupt_control[INT_OVF_IE] &
    state_reg.interrupt_control[INT_OVF_FLAG];
  // Other sources use the same global gate.
  assign irq_o = |(state_reg.irq_status & state_reg.irq_mask) |
    (state_reg.interrupt_control[INT_GLOBAL_EN] & |other_irq_i);

endmodule

`default_nettype wire

//--- dv/timer8_props.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// Pin-level checks of bus, interrupt and clear.
// ************************************************
module timer8_props
  import timer8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic sleep_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic watchdog_clear_o,
  input wire logic timer_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr_req = cyc_i && stb_i && we_i;
  wire logic rd_int = cyc_i && stb_i && !we_i && adr_i == {1'b0, ADDR_INTCTL};
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack not one cycle after request");
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  flag_hold_a: assert property ($fell(timer_irq_o) |-> $past(wr_req))
    else $error("timer interrupt dropped without a write");
  sleep_freeze_a: assert property ($rose(timer_irq_o) && $past(sleep_i)
    && $past(sleep_i, 2) && $past(sleep_i, 3) |-> $past(wr_req))
    else $error("timer interrupt rose during sleep");
  global_gate_a: assert property (ack_o && $past(rd_int)
    && !dat_o[INT_GLOBAL_EN] |-> !timer_irq_o)
    else $error("timer interrupt with global enable off");
  ie_gate_a: assert property (ack_o && $past(rd_int)
    && !dat_o[INT_OVF_IE] |-> !timer_irq_o)
    else $error("timer interrupt with overflow enable off");
  irq_on_a: assert property (ack_o && $past(rd_int) && dat_o[INT_GLOBAL_EN]
    && dat_o[INT_OVF_IE] && dat_o[INT_OVF_FLAG] |-> timer_irq_o)
    else $error("timer interrupt missing");
  wdt_clear_a: assert property (watchdog_clear_instruction_i
    |-> watchdog_clear_o)
    else $error("watchdog clear not passed on");
endmodule
bind timer8 timer8_props timer8_props_i (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_o, .ack_o, .sleep_i, .watchdog_clear_instruction_i,
  .watchdog_clear_o, .timer_irq_o);
`default_nettype wire

//--- dv/timer8_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
// ************************************************
// Register-level tests of the eight-bit timer.
// ************************************************
module timer8_tb;
  import timer8_pkg::*;
  localparam logic [4:0] OPT = {1'b0, ADDR_OPTION};
  localparam logic [4:0] ICT = {1'b0, ADDR_INTCTL};
  localparam logic [4:0] STA = {1'b0, ADDR_IRQ_STATUS};
  localparam logic [4:0] CNT = ADDR_COUNTER_W;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, sleep_i, ack_o;
  logic external_count_input_i, watchdog_clear_instruction_i;
  logic watchdog_tick_o, watchdog_clear_o, timer_irq_o, irq_o;
  logic [4:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rv;
  logic [7:0] other_irq_i;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_tick = 0;
  timer8 timer8_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .sleep_i, .external_count_input_i,
    .watchdog_clear_instruction_i, .other_irq_i, .watchdog_tick_o,
    .watchdog_clear_o, .timer_irq_o, .irq_o);
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rv = dat_o;
    if (n >= 50) n_mismatch++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, e}, rv)
  endtask
  task automatic span(input logic [7:0] lo, input logic [7:0] hi);
    bus(1'b0, CNT, 8'h00);
    `CHK("count", 1'b1, rv[7:0] inside {[lo:hi]})
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {rst_i, sel_i, other_irq_i} = {1'b1, 4'hF, 8'h00};
    {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    {sleep_i, external_count_input_i, watchdog_clear_instruction_i} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OPT, OPTION_RESET, "option");
    rd(ICT, INTCTL_RESET, "intctl");
    rd(5'h18, 8'h00, "unmapped");
    bus(1'b1, OPT, 8'h08);
    bus(1'b1, CNT, 8'h00);
    repeat (40) @(posedge clk_i);
    span(8'h07, 8'h09);
    bus(1'b1, ADDR_DOG_CLEAR, 8'h01);
    rd(STA, 8'h02, "dog clear reg");
    bus(1'b1, STA, 8'h02);
    for (int n = 0; n < 8; n++) begin
      bus(1'b1, OPT, {5'h00, 3'(n)});
      bus(1'b1, CNT, 8'h00);
      repeat (64 << n) @(posedge clk_i);
      span(8'h06, 8'h08);
    end
    bus(1'b1, ADDR_DOG_CLEAR, 8'h01);
    bus(1'b1, CNT, 8'h00);
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, OPT, (e == 1) ? 8'h38 : 8'h28);
      bus(1'b1, CNT, 8'h00);
      repeat (12) @(posedge clk_i);
      external_count_input_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(CNT, (e == 1) ? 8'h00 : 8'h01, "rise");
      external_count_input_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(CNT, 8'h01, "fall");
    end
    sleep_i <= 1'b1;
    external_count_input_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    external_count_input_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(CNT, 8'h01, "sleep count");
    sleep_i <= 1'b0;
    bus(1'b1, OPT, 8'h08);
    bus(1'b1, ICT, 8'h80);
    bus(1'b1, CNT, 8'hFF);
    repeat (20) @(posedge clk_i);
    rd(ICT, 8'h84, "flag");
    `CHK("tirq off", 1'b0, timer_irq_o)
    bus(1'b1, ICT, 8'hA4);
    `CHK("tirq on", 1'b1, timer_irq_o)
    rd(STA, 8'h01, "status");
    `CHK("irq masked", 1'b0, irq_o)
    bus(1'b1, ADDR_IRQ_MASK_HI, 8'h01);
    `CHK("irq unmasked", 1'b1, irq_o)
    bus(1'b1, STA, 8'h01);
    `CHK("irq w1c", 1'b0, irq_o)
    rd(ICT, 8'hA4, "flag kept");
    bus(1'b1, ICT, 8'hA0);
    `CHK("tirq cleared", 1'b0, timer_irq_o)
    other_irq_i <= 8'h01;
    repeat (2) @(posedge clk_i);
    `CHK("other global", 1'b1, irq_o)
    bus(1'b1, ICT, 8'h20);
    repeat (2) @(posedge clk_i);
    `CHK("other no global", 1'b0, irq_o)
    bus(1'b1, CNT, 8'h10);
    sleep_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    rd(CNT, 8'h10, "sleep timer");
    sleep_i <= 1'b0;
    watchdog_clear_instruction_i <= 1'b1;
    @(posedge clk_i);
    watchdog_clear_instruction_i <= 1'b0;
    rd(STA, 8'h02, "dog clear");
    repeat (80) begin
      @(posedge clk_i);
      n_tick += int'(watchdog_tick_o);
    end
    `CHK("dog ticks", 10, n_tick)
    give_verdict();
  end
endmodule
`default_nettype wire
